// File: rocsel_core.sv
/*
 * Output selection, allowed rate choice and rate/reference status of a serial
 * video reclocker, with its register port.
 * Assumes register access arrives as a simple synchronous read/write port in
 * the serial register domain, already deserialised; recovered clock phase
 * marks reclk_edge_i are synchronous to mclk_i.
 */
`timescale 1ns/1ps
`include "rocsel_params.svh"
module rocsel_core #(
    parameter int REF_WIN = `ROC_REF_WINDOW_CYC
) (
    input  wire logic       mclk_i,
    input  wire logic       rstn_i,
    input  wire logic       reg_mode_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic [7:0]      reg_rdata_o,
    output logic            reg_rvalid_o,
    input  wire logic       bypass_pin_i,
    input  wire logic       mute_n_pin_i,
    input  wire logic       clock_out_enable_i,
    input  wire logic       rate_pin_low_i,
    input  wire logic       rate_pin_high_i,
    input  wire logic       enable_i,
    input  wire logic       cdr_locked_i,
    input  wire logic       rate_supported_i,
    input  wire logic [2:0] cdr_rate_i,
    input  wire logic       reclk_edge_i,
    input  wire logic       reference_input_i,
    input  wire logic       sd_reclk_i,
    input  wire logic       sd_byp_i,
    input  wire logic       rec_clk_i,
    output logic [1:0]      allowed_rate_o,
    output logic            lock_detect_o,
    output logic            standard_def_indicator_o,
    output logic            reference_output_o,
    output logic            drivers_on_o,
    output logic            serial_out_a_o,
    output logic            serial_out_b_o
);
    // ==========================================================
    // Registers
    logic [7:0] out_func;      // output_function_control
    logic [7:0] pin_ovr;       // pin_override_control
    logic [7:0] mute_lvl;      // Holds the muted level bit
    logic [7:0] rate_val;      // rate_select_value
    logic [7:0] rate_ovr;      // rate_select_override
    logic [7:0] man_sel;       // output_manual_select
    logic [2:0] rate_code;     // Locked rate code
    logic       ref_present;   // reference_present
    logic       frac_flag;     // fractional_rate_flag

    // Write strobes
    wire wr_func = reg_wr_i && reg_mode_i && (reg_addr_i == `ROC_REG_OUT_FUNC);
    wire wr_povr = reg_wr_i && reg_mode_i && (reg_addr_i == `ROC_REG_PIN_OVR);
    wire wr_mlvl = reg_wr_i && reg_mode_i && (reg_addr_i == `ROC_REG_MUTE_LEVEL);
    wire wr_rval = reg_wr_i && reg_mode_i && (reg_addr_i == `ROC_REG_RATE_VAL);
    wire wr_rovr = reg_wr_i && reg_mode_i && (reg_addr_i == `ROC_REG_RATE_OVR);
    wire wr_msel = reg_wr_i && reg_mode_i && (reg_addr_i == `ROC_REG_MAN_SEL);

    // ==========================================================
    // Register writes; status registers take no write
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            out_func <= `ROC_RST_OUT_FUNC;
            pin_ovr  <= `ROC_RST_ZERO;
            mute_lvl <= `ROC_RST_ZERO;
            rate_val <= `ROC_RST_ZERO;
            rate_ovr <= `ROC_RST_ZERO;
            man_sel  <= `ROC_RST_ZERO;
        end else begin
            if (wr_func) out_func <= reg_wdata_i;
            if (wr_povr) pin_ovr  <= reg_wdata_i;
            if (wr_mlvl) mute_lvl <= reg_wdata_i;
            if (wr_rval) rate_val <= reg_wdata_i;
            if (wr_rovr) rate_ovr <= reg_wdata_i;
            if (wr_msel) man_sel  <= reg_wdata_i;
        end
    end

    // ==========================================================
    // Read mux, unmapped reads as zero
    logic [7:0] rd_mux;
    always_comb begin
        unique case (reg_addr_i)
            `ROC_REG_RATE_STATUS: rd_mux = {rate_code, 5'h00};
            `ROC_REG_PIN_OVR:     rd_mux = pin_ovr;
            `ROC_REG_OUT_FUNC:    rd_mux = out_func;
            `ROC_REG_MUTE_LEVEL:  rd_mux = mute_lvl;
            `ROC_REG_RATE_VAL:    rd_mux = rate_val;
            `ROC_REG_RATE_OVR:    rd_mux = rate_ovr;
            `ROC_REG_MAN_SEL:     rd_mux = man_sel;
            `ROC_REG_REF_STATUS:  rd_mux = {4'h0, ref_present, frac_flag, 2'h0};
            default:              rd_mux = 8'h00;
        endcase
    end

    // Read data registered, answer one cycle after the strobe
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            reg_rdata_o  <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i && reg_mode_i;
            if (reg_rd_i && reg_mode_i) reg_rdata_o <= rd_mux;
        end
    end

    // ==========================================================
    // Allowed rate choice
    wire [1:0] pin_rate = {rate_pin_high_i, rate_pin_low_i};
    wire       use_rreg = reg_mode_i && rate_ovr[`ROC_BIT_RATE_OVR];
    assign allowed_rate_o = use_rreg ? rate_val[1:0] : pin_rate;

    // ==========================================================
    // Effective controls; pin mute is active low, register bit likewise
    wire bypass_c = reg_mode_i ? out_func[`ROC_BIT_BYPASS] : bypass_pin_i;
    wire mute_n_c = reg_mode_i ? out_func[`ROC_BIT_MUTE]   : mute_n_pin_i;
    wire clk_en_c = reg_mode_i ? out_func[`ROC_BIT_CLK_EN] : clock_out_enable_i;
    wire manual   = reg_mode_i && pin_ovr[`ROC_BIT_MAN_OVR];

    // Lock is never shown while bypass is in force or rate unsupported
    assign lock_detect_o = cdr_locked_i && rate_supported_i && !bypass_c && enable_i;
    wire   lk = lock_detect_o;

    // Decode of the output a selector
    function automatic rocsel_pkg::rocsel_src_t dec_a(input logic [1:0] s, input logic l);
        unique case (s)
            2'h1:    dec_a = rocsel_pkg::ROCSEL_SRC_BYP;
            2'h2:    dec_a = rocsel_pkg::ROCSEL_SRC_MUTE;
            default: dec_a = l ? rocsel_pkg::ROCSEL_SRC_RECLK : rocsel_pkg::ROCSEL_SRC_BYP;
        endcase
    endfunction : dec_a

    // Decode of the output b selector
    function automatic rocsel_pkg::rocsel_src_t dec_b(input logic [1:0] s, input logic l);
        unique case (s)
            2'h0: dec_b = l ? rocsel_pkg::ROCSEL_SRC_CLK : rocsel_pkg::ROCSEL_SRC_MUTE;
            2'h1: dec_b = l ? rocsel_pkg::ROCSEL_SRC_RECLK : rocsel_pkg::ROCSEL_SRC_BYP;
            2'h2: dec_b = rocsel_pkg::ROCSEL_SRC_MUTE;
            2'h3: dec_b = rocsel_pkg::ROCSEL_SRC_BYP;
        endcase
    endfunction : dec_b

    // Combined mapping: mute over all, else lock picks reclocked or bypass; b with clock enable picks clock or mute
    wire rocsel_pkg::rocsel_src_t comb_a = !mute_n_c ? rocsel_pkg::ROCSEL_SRC_MUTE :
        (lk ? rocsel_pkg::ROCSEL_SRC_RECLK : rocsel_pkg::ROCSEL_SRC_BYP);
    wire rocsel_pkg::rocsel_src_t comb_b = !mute_n_c ? rocsel_pkg::ROCSEL_SRC_MUTE :
        (clk_en_c ? (lk ? rocsel_pkg::ROCSEL_SRC_CLK : rocsel_pkg::ROCSEL_SRC_MUTE) :
                    (lk ? rocsel_pkg::ROCSEL_SRC_RECLK : rocsel_pkg::ROCSEL_SRC_BYP));

    // Manual path; bypass bit clears lock so clock falls to mute as well
    wire rocsel_pkg::rocsel_src_t man_a = dec_a(man_sel[`ROC_SEL_A_HI:`ROC_SEL_A_LO], lk);
    wire rocsel_pkg::rocsel_src_t man_b = dec_b(man_sel[`ROC_SEL_B_HI:`ROC_SEL_B_LO], lk);
    wire rocsel_pkg::rocsel_src_t frc_a =
        (bypass_c && man_a != rocsel_pkg::ROCSEL_SRC_MUTE) ? rocsel_pkg::ROCSEL_SRC_BYP : man_a;
    wire rocsel_pkg::rocsel_src_t frc_b =
        (bypass_c && man_b == rocsel_pkg::ROCSEL_SRC_RECLK) ? rocsel_pkg::ROCSEL_SRC_BYP : man_b;

    wire rocsel_pkg::rocsel_src_t want_a = manual ? frc_a : comb_a;
    wire rocsel_pkg::rocsel_src_t want_b = manual ? frc_b : comb_b;
    wire                          want_h = mute_lvl[`ROC_BIT_MUTE_HIGH];

    // ==========================================================
    // Selection words pass a two-entry buffer; offered only on change so a
    // slow recovered clock cannot drop a late setting
    rocsel_sel_if sel_if ();
    logic [4:0] last_word;   // Last word pushed
    wire  [4:0] want_word = {want_h, want_a, want_b};
    assign sel_if.valid   = (want_word != last_word);
    assign sel_if.src_a   = want_a;
    assign sel_if.src_b   = want_b;
    assign sel_if.mute_hi = want_h;

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) last_word <= 5'h00;
        else if (sel_if.valid && sel_if.ready) last_word <= want_word;
    end

    logic                    buf_avail;
    rocsel_pkg::rocsel_src_t buf_a;
    rocsel_pkg::rocsel_src_t buf_b;
    logic                    buf_h;

    rocsel_skid #(.DEPTH(2)) u_skid (
        .mclk_i    (mclk_i),
        .rstn_i    (rstn_i),
        .in_if     (sel_if),
        .take_i    (reclk_edge_i),
        .avail_o   (buf_avail),
        .src_a_o   (buf_a),
        .src_b_o   (buf_b),
        .mute_hi_o (buf_h)
    );

    // Applied selection, updated only on a recovered clock boundary
    rocsel_pkg::rocsel_src_t cur_a;
    rocsel_pkg::rocsel_src_t cur_b;
    logic                    cur_h;
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            cur_a <= rocsel_pkg::ROCSEL_SRC_MUTE;
            cur_b <= rocsel_pkg::ROCSEL_SRC_MUTE;
            cur_h <= 1'b0;
        end else if (buf_avail && reclk_edge_i) begin
            cur_a <= buf_a;
            cur_b <= buf_b;
            cur_h <= buf_h;
        end
    end

    // Per-output source mux, muted level per control bit
    function automatic logic pick(input rocsel_pkg::rocsel_src_t s, input logic r,
                                  input logic b, input logic c, input logic h);
        unique case (s)
            rocsel_pkg::ROCSEL_SRC_RECLK: pick = r;
            rocsel_pkg::ROCSEL_SRC_BYP:   pick = b;
            rocsel_pkg::ROCSEL_SRC_CLK:   pick = c;
            rocsel_pkg::ROCSEL_SRC_MUTE:  pick = h;
        endcase
    endfunction : pick

    assign drivers_on_o   = enable_i;
    assign serial_out_a_o = enable_i && pick(cur_a, sd_reclk_i, sd_byp_i, rec_clk_i, cur_h);
    assign serial_out_b_o = enable_i && pick(cur_b, sd_reclk_i, sd_byp_i, rec_clk_i, cur_h);

    // ==========================================================
    // Reference forwarding stays active while disabled
    assign reference_output_o = reference_input_i;

    // Reference detector: count rising edges in a fixed window
    rocsel_pkg::rocsel_ref_t ref_st;
    logic [15:0] win_cnt;   // Window timer
    logic [7:0]  edge_cnt;  // Edges seen in window
    logic        ref_q;     // Last reference level
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            ref_st      <= rocsel_pkg::ROCSEL_REF_IDLE;
            win_cnt     <= 16'h0000;
            edge_cnt    <= 8'h00;
            ref_q       <= 1'b0;
            ref_present <= 1'b0;
        end else begin
            ref_q <= reference_input_i;
            unique case (ref_st)
                rocsel_pkg::ROCSEL_REF_IDLE: begin
                    win_cnt  <= 16'h0000;
                    edge_cnt <= 8'h00;
                    ref_st   <= rocsel_pkg::ROCSEL_REF_COUNT;
                end
                rocsel_pkg::ROCSEL_REF_COUNT: begin
                    win_cnt <= win_cnt + 16'h0001;
                    if (reference_input_i && !ref_q && edge_cnt != 8'hFF) begin
                        edge_cnt <= edge_cnt + 8'h01;
                    end
                    if (win_cnt == 16'(REF_WIN - 1)) ref_st <= rocsel_pkg::ROCSEL_REF_JUDGE;
                end
                rocsel_pkg::ROCSEL_REF_JUDGE: begin
                    ref_present <= (edge_cnt >= `ROC_REF_MIN_EDGES);
                    ref_st      <= rocsel_pkg::ROCSEL_REF_IDLE;
                end
                default: ref_st <= rocsel_pkg::ROCSEL_REF_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Rate status; fractional codes fold to integer ones without reference
    wire [2:0] fold = (cdr_rate_i == `ROC_RC_HD_FRAC) ? `ROC_RC_HD :
                      (cdr_rate_i == `ROC_RC_3G_FRAC) ? `ROC_RC_3G : cdr_rate_i;
    wire [2:0] next_rate = !lk ? `ROC_RC_UNLOCKED :
                           (ref_present ? cdr_rate_i : fold);
    wire next_frac = ref_present && lk &&
                     (cdr_rate_i == `ROC_RC_HD_FRAC || cdr_rate_i == `ROC_RC_3G_FRAC);

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            rate_code <= `ROC_RC_UNLOCKED;
            frac_flag <= 1'b0;
            standard_def_indicator_o <= 1'b0;
        end else begin
            rate_code <= next_rate;
            frac_flag <= next_frac;
            standard_def_indicator_o <= lk && (cdr_rate_i == `ROC_RC_270);
        end
    end

    // ==========================================================
    // Checks
    chk_sd_unlock_low: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        !lk |=> !standard_def_indicator_o) else $error("indicator high while unlocked");
    chk_rate_unlock: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        !lk |=> rate_code == `ROC_RC_UNLOCKED) else $error("rate not unlocked");
    chk_noref_frac: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        !ref_present |=> rate_code != `ROC_RC_HD_FRAC &&
        rate_code != `ROC_RC_3G_FRAC) else $error("frac code no ref");
    chk_frac_flag: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        frac_flag |-> $past(ref_present)) else $error("frac flag without ref");
    chk_bypass_nolock: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        bypass_c |-> !lock_detect_o) else $error("lock during bypass");
    chk_rate_pins: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        !use_rreg |-> allowed_rate_o == pin_rate) else $error("rate pins ignored");
    chk_sel_boundary: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        !$past(reclk_edge_i) |-> $stable(cur_a) && $stable(cur_b)) else $error("glitch switch");
    chk_mute_pin: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        !reg_mode_i && !mute_n_pin_i |-> want_a == rocsel_pkg::ROCSEL_SRC_MUTE &&
        want_b == rocsel_pkg::ROCSEL_SRC_MUTE) else $error("pin mute failed");
    chk_disable_out: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        !enable_i |-> !serial_out_a_o && !serial_out_b_o) else $error("driver on disabled");

    cov_manual: cover property (@(posedge mclk_i) manual && lk);
    cov_ref: cover property (@(posedge mclk_i) $rose(ref_present));
    cov_clk_b: cover property (@(posedge mclk_i) cur_b == rocsel_pkg::ROCSEL_SRC_CLK);
    cov_rovr: cover property (@(posedge mclk_i) use_rreg);
endmodule : rocsel_core

// File: rocsel_params.svh
/*
 * Register offsets, field positions, codes and timing constants of the reclocker
 * output and rate control block.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef ROCSEL_PARAMS_SVH
`define ROCSEL_PARAMS_SVH

// ==========================================================
// Register offsets
`define ROC_REG_RATE_STATUS   8'h03
`define ROC_REG_PIN_OVR       8'h09
`define ROC_REG_OUT_FUNC      8'h12
`define ROC_REG_MUTE_LEVEL    8'h14
`define ROC_REG_RATE_VAL      8'h1C
`define ROC_REG_RATE_OVR      8'h1D
`define ROC_REG_MAN_SEL       8'h1E
`define ROC_REG_REF_STATUS    8'h41

// ==========================================================
// Field positions
`define ROC_BIT_CLK_EN        0
`define ROC_BIT_MUTE          1
`define ROC_BIT_BYPASS        2
`define ROC_BIT_MAN_OVR       5
`define ROC_BIT_MUTE_HIGH     7
`define ROC_BIT_RATE_OVR      0
`define ROC_BIT_FRAC          2
`define ROC_BIT_REF_DET       3
`define ROC_SEL_A_HI          6
`define ROC_SEL_A_LO          5
`define ROC_SEL_B_HI          4
`define ROC_SEL_B_LO          3
`define ROC_RATE_HI           7
`define ROC_RATE_LO           5

// ==========================================================
// Reset values
`define ROC_RST_OUT_FUNC      8'h02
`define ROC_RST_ZERO          8'h00

// ==========================================================
// Locked rate codes
`define ROC_RC_125            3'h0
`define ROC_RC_270            3'h1
`define ROC_RC_HD_FRAC        3'h2
`define ROC_RC_HD             3'h3
`define ROC_RC_3G_FRAC        3'h4
`define ROC_RC_3G             3'h5
`define ROC_RC_UNLOCKED       3'h7

// ==========================================================
// Allowed rate choices
`define ROC_AR_AUTO           2'h0
`define ROC_AR_SD             2'h1
`define ROC_AR_HD3G           2'h2
`define ROC_AR_MADI           2'h3

// ==========================================================
// Reference detection timing
`define ROC_CLK_MHZ           50
`define ROC_REF_WINDOW_US     2
`define ROC_REF_WINDOW_CYC    (`ROC_REF_WINDOW_US * `ROC_CLK_MHZ)
`define ROC_REF_MIN_EDGES     8'h10

`endif

// File: rocsel_pkg.sv
/*
 * Types shared by the reclocker output and rate control modules.
 * Assumes rocsel_params.svh is available for constants.
 */
package rocsel_pkg;
    // Source carried by one serial output
    typedef enum logic [1:0] {
        ROCSEL_SRC_MUTE  = 2'h0,
        ROCSEL_SRC_RECLK = 2'h1,
        ROCSEL_SRC_BYP   = 2'h3,
        ROCSEL_SRC_CLK   = 2'h2
    } rocsel_src_t;

    // Reference detector state
    typedef enum logic [1:0] {
        ROCSEL_REF_IDLE  = 2'h0,
        ROCSEL_REF_COUNT = 2'h1,
        ROCSEL_REF_JUDGE = 2'h3
    } rocsel_ref_t;
endpackage : rocsel_pkg

// File: rocsel_sel_if.sv
/*
 * Carrier for output selection words between the control core and the
 * two-entry selection buffer.
 * Assumes both ends share mclk_i.
 */
`timescale 1ns/1ps
interface rocsel_sel_if;
    logic                 valid;   // Word offered
    logic                 ready;   // Word accepted
    rocsel_pkg::rocsel_src_t src_a; // Source of output a
    rocsel_pkg::rocsel_src_t src_b; // Source of output b
    logic                 mute_hi; // Muted level

    modport src (output valid, output src_a, output src_b, output mute_hi, input ready);
    modport snk (input valid, input src_a, input src_b, input mute_hi, output ready);
endinterface : rocsel_sel_if

// File: rocsel_skid.sv
/*
 * Two-entry buffer for output selection words.
 * Assumes one clock; drain side may stall via take_i.
 */
`timescale 1ns/1ps
module rocsel_skid #(
    parameter int DEPTH = 2
) (
    input  wire logic                    mclk_i,
    input  wire logic                    rstn_i,
    rocsel_sel_if.snk                    in_if,
    input  wire logic                    take_i,
    output logic                         avail_o,
    output rocsel_pkg::rocsel_src_t      src_a_o,
    output rocsel_pkg::rocsel_src_t      src_b_o,
    output logic                         mute_hi_o
);
    // ==========================================================
    // Storage
    logic [4:0] mem [DEPTH];  // Packed word: mute_hi, src_a, src_b
    logic       wptr;         // Write index
    logic       rptr;         // Read index
    logic [1:0] fill;         // Entries held
    wire        push = in_if.valid && in_if.ready;
    wire        pop  = avail_o && take_i;

    assign in_if.ready = (fill != 2'(DEPTH));
    assign avail_o     = (fill != 2'h0);
    assign mute_hi_o   = mem[rptr][4];
    assign src_a_o     = rocsel_pkg::rocsel_src_t'(mem[rptr][3:2]);
    assign src_b_o     = rocsel_pkg::rocsel_src_t'(mem[rptr][1:0]);

    // ==========================================================
    // Pointer and fill update
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            wptr <= 1'b0;
            rptr <= 1'b0;
            fill <= 2'h0;
            mem[0] <= 5'h00;
            mem[1] <= 5'h00;
        end else begin
            if (push) begin
                mem[wptr] <= {in_if.mute_hi, in_if.src_a, in_if.src_b};
                wptr      <= ~wptr;
            end
            if (pop) begin
                rptr <= ~rptr;
            end
            fill <= fill + 2'(push) - 2'(pop);
        end
    end

    chk_no_overfill: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        fill <= 2'(DEPTH)) else $error("buffer overfilled");
endmodule : rocsel_skid

// File: rocsel_src_model.sv
/* Upstream source model: recovered clock, boundary marks, reference.
   Assumes the bench clock; hold_i stalls the boundary marks. */
`timescale 1ns/1ps
// ====================
// Source model
module rocsel_src_model (
    input  wire logic mclk_i,
    input  wire logic hold_i,
    input  wire logic ref_on_i,
    output logic      edge_o,
    output logic      rclk_o,
    output logic      ref_o
);
    logic [1:0] cnt = 2'h0; // Boundary divider
    // Mark every fourth cycle; an absent reference sits grounded
    always @(posedge mclk_i) begin
        cnt    <= cnt + 2'h1;
        edge_o <= (cnt == 2'h3) && !hold_i;
        rclk_o <= cnt[0];
        ref_o  <= ref_on_i & cnt[0];
    end
endmodule : rocsel_src_model

// File: test_reclocker_output_rate_control.sv
/* Self-checking bench of the output and rate control core.
   Assumes rocsel_src_model stands upstream. */
`timescale 1ns/1ps
// ====================
// Bench
module test_reclocker_output_rate_control;
    logic mclk_i = 1'b0, rstn_i = 1'b0, mode = 1, wr = 0, rd = 0, byp = 0, mute_n = 1, cken = 0;
    logic rlo = 0, rhi = 0, en = 1, lk = 0, sup = 1, ref_on = 0, hold = 0, dr = 0, db = 0;
    logic edg, rclk, refo, rval, lkd, sdi, refout, drv, oa, ob, b, mu, c, l, L;
    logic [7:0] addr = 8'h00, wdat = 8'h00, rdata;
    logic [7:0] expq[$];     // Read results in flight
    logic [2:0] rate = 3'h0;
    logic [1:0] arate;
    logic [31:0] seed = 32'h4D;
    int n_fail = 0, cmp_count = 0, ea, eb;
    always #10 mclk_i = ~mclk_i;
    rocsel_src_model src (.mclk_i(mclk_i), .hold_i(hold), .ref_on_i(ref_on), .edge_o(edg),
        .rclk_o(rclk), .ref_o(refo));
    rocsel_core uut (.mclk_i(mclk_i), .rstn_i(rstn_i), .reg_mode_i(mode), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdat), .reg_rdata_o(rdata),
        .reg_rvalid_o(rval), .bypass_pin_i(byp), .mute_n_pin_i(mute_n),
        .clock_out_enable_i(cken), .rate_pin_low_i(rlo), .rate_pin_high_i(rhi),
        .enable_i(en), .cdr_locked_i(lk), .rate_supported_i(sup), .cdr_rate_i(rate),
        .reclk_edge_i(edg), .reference_input_i(refo), .sd_reclk_i(dr), .sd_byp_i(db),
        .rec_clk_i(rclk), .allowed_rate_o(arate), .lock_detect_o(lkd),
        .standard_def_indicator_o(sdi), .reference_output_o(refout),
        .drivers_on_o(drv), .serial_out_a_o(oa), .serial_out_b_o(ob));
    function automatic logic xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[0];
    endfunction : xs
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        cmp_count++;
        if (seen !== want) begin
            n_fail++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i) {wr, addr, wdat} <= {1'b1, a, d};
        @(posedge mclk_i) wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        expq.push_back(e);
        @(posedge mclk_i) {rd, addr} <= {1'b1, a};
        @(posedge mclk_i) rd <= 1'b0;
    endtask : rd_reg
    // Levels a source code stands for: 0 mute, 1 reclocked, 2 clock, 3 bypassed
    function automatic logic lvl(input int s, input logic mh);
        return (s == 0) ? mh : (s == 1) ? dr : (s == 2) ? rclk : db;
    endfunction : lvl
    // Let selection land on a boundary, then watch outputs under random data
    task automatic settle(input int sa, input int sb, input logic mh, input logic lz);
        repeat (12) @(posedge mclk_i);
        repeat (4) begin
            @(posedge mclk_i) {dr, db} <= {xs(), xs()};
            @(negedge mclk_i) check({oa, ob, lkd, drv},
                {lvl(sa, mh), lvl(sb, mh), lz, en});
        end
        // Hand back on a rising edge so the next drive lands there
        @(posedge mclk_i);
    endtask : settle
    task automatic finish_test();
        // A read that never answered leaves its note behind
        if (expq.size() != 0) n_fail++;
        if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : finish_test
    // Read results leave the queue in order
    always @(negedge mclk_i) if (rval === 1'b1) check(rdata, expq.pop_front());
    initial begin
        #400000 n_fail++;
        finish_test();
    end
    initial begin
        repeat (5) @(posedge mclk_i);
        rstn_i <= 1'b1;
        rd_reg(8'h12, 8'h02);
        wr_reg(8'h03, 8'hFF);
        rd_reg(8'h03, 8'hE0);
        rd_reg(8'h55, 8'h00);
        for (int i = 0; i < 32; i++) begin
            {b, mu, c, l} = i[3:0];
            mode <= i[4];
            lk <= l;
            {byp, mute_n, cken} <= i[4] ? ~{b, mu, c} : {b, mu, c};
            if (i[4]) wr_reg(8'h12, {5'h00, b, mu, c});
            L = l & !b;
            ea = !mu ? 0 : L ? 1 : 3;
            eb = !mu ? 0 : c ? (L ? 2 : 0) : (L ? 1 : 3);
            settle(ea, eb, 1'b0, L);
        end
        wr_reg(8'h09, 8'h20);
        wr_reg(8'h14, 8'h80);
        for (int i = 0; i < 32; i++) begin
            {b, ea, eb} = {i[4], 30'h0, i[3:2], 30'h0, i[1:0]};
            wr_reg(8'h1E, {1'h0, i[3:0], 3'h0});
            wr_reg(8'h12, {5'h00, b, 2'h2});
            ea = (ea == 2) ? 0 : (ea == 1 || b) ? 3 : 1;
            eb = (eb == 0) ? (b ? 0 : 2) : (eb == 1) ? (b ? 3 : 1) : (eb == 2) ? 0 : 3;
            settle(ea, eb, 1'b1, !b);
        end
        // Drop the bypass left by the last manual pass so lock can show again
        wr_reg(8'h12, 8'h02);
        hold <= 1'b1;
        wr_reg(8'h1E, 8'h00);
        wr_reg(8'h1E, 8'h20);
        wr_reg(8'h1E, 8'h48);
        hold <= 1'b0;
        settle(0, 1, 1'b1, 1'b1);
        for (int i = 0; i < 12; i++) begin
            mode <= (i > 3);
            {rhi, rlo} <= (i > 7) ? ~i[1:0] : i[1:0];
            if (i == 8) wr_reg(8'h1D, 8'h01);
            if (i > 7) wr_reg(8'h1C, {6'h00, i[1:0]});
            repeat (3) @(posedge mclk_i);
            check({6'h00, arate}, {6'h00, i[1:0]});
        end
        for (int r = 0; r < 2; r++) begin
            ref_on <= r[0];
            repeat (300) @(posedge mclk_i);
            for (int k = 0; k < 7; k++) begin
                rate <= k[2:0];
                lk <= (k < 6);
                repeat (3) @(posedge mclk_i);
                ea = (k == 6) ? 7 : (!r && (k == 2 || k == 4)) ? k + 1 : k;
                rd_reg(8'h03, {ea[2:0], 5'h00});
                rd_reg(8'h41, {4'h0, r[0], r[0] & (k == 2 || k == 4), 2'h0});
                check({sdi, refout}, {k == 1, refo});
            end
        end
        {en, lk} <= 2'h1;
        settle(0, 0, 1'b0, 1'b0);
        check({7'h00, drv}, 8'h00);
        rd_reg(8'h1C, 8'h03);
        repeat (4) @(posedge mclk_i);
        finish_test();
    end
endmodule : test_reclocker_output_rate_control
